//--- design/cmc_lut_rom.sv
// Registered lookup table for the three kernel modes
`timescale 1ns/10ps
module cmc_lut_rom
  import cmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire cmc_mode_t   mode,
  input  wire logic [3:0]  iter,
  output logic      [19:0] entry
);

  logic [19:0] next_entry;

  always_comb begin
    case (mode)
      CMC_CIRCULAR: begin
        next_entry = CMC_ATAN_LUT[iter]; // RULE13
      end
      CMC_HYPERBOLIC: begin
        next_entry = CMC_ATANH_LUT[cmc_hyp_shift(iter)]; // RULE13
      end
      default: begin
        // No stored table: powers of two in 1.15
        next_entry = CMC_LIN_ONE >> iter; // RULE15
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      entry <= '0;
    end else begin
      entry <= next_entry; // RULE2
    end
  end

endmodule

//--- design/cmc_pkg.sv
// Constants, types and tables shared by the coprocessor files
// Notes on behaviour
// (RULE1) Circular, linear, hyperbolic; rotation and vectoring
// (RULE2) Lookup tables built in, 20-bit signed entries
// (RULE3) Circular vectoring takes full signed 16-bit X, Y
// (RULE4) Circular rotation takes full range Z angle
// (RULE5) Module off freezes the whole kernel
// (RULE6) Software sees operands and results as 16 bits
// (RULE7) X, Y kernel 24 bits plus 2 overflow
// (RULE8) Z kernel 20 bits plus 1 overflow
// (RULE9) Keep bits reuse last kernel value
// (RULE10) Sixteen iterations, done within 41 cycles
// (RULE11) Two's complement; X result optionally unsigned
// (RULE12) Software gives X and Y same form
// (RULE13) Angle tables are S19 codes, pi scaled
// (RULE14) Circular, hyperbolic Z result is S15
// (RULE15) Linear table emulated in 1.15 form
// (RULE16) Linear Z result is S4.11
// (RULE17) Results truncated, no rounding
// (RULE18) Completion sets flag; interrupt when enabled
// (RULE19) Interrupt shares polling level 9 node
// (RULE20) Done flag sticky; busy shown while iterating
// (RULE21) No operand writes or restart while busy
package cmc_pkg;

  localparam int CMC_ACC_W = 16;
  localparam int CMC_XY_W  = 26;
  localparam int CMC_Z_W   = 21;
  localparam int CMC_LUT_W = 20;

  // Register byte offsets
  localparam logic [4:0] CMC_REG_CTRL = 5'h00;
  localparam logic [4:0] CMC_REG_STAT = 5'h04;
  localparam logic [4:0] CMC_REG_XDAT = 5'h08;
  localparam logic [4:0] CMC_REG_YDAT = 5'h0c;
  localparam logic [4:0] CMC_REG_ZDAT = 5'h10;

  // Control and status bit positions
  localparam int CMC_START_BIT = 0;
  localparam int CMC_CTRL_LSB  = 1;
  localparam int CMC_CTRL_MSB  = 9;
  localparam int CMC_BUSY_BIT  = 0;
  localparam int CMC_EOC_BIT   = 1;

  localparam logic [3:0] CMC_LAST_ITER  = 4'hf;
  localparam logic [3:0] CMC_HYP_REP_A  = 4'h4;
  localparam logic [3:0] CMC_HYP_REP_B  = 4'he;
  localparam int         CMC_MAX_CYCLES = 41;

  // Angle codes in the Z kernel: pi is 2^19
  localparam logic signed [20:0] CMC_Z_PI      = 21'sh080000;
  localparam logic signed [20:0] CMC_Z_HALF_PI = 21'sh040000;
  localparam logic [19:0]        CMC_LIN_ONE   = 20'h08000;

  typedef enum logic [1:0] {
    CMC_LINEAR     = 2'h0,
    CMC_CIRCULAR   = 2'h1,
    CMC_RESERVED   = 2'h2,
    CMC_HYPERBOLIC = 2'h3
  } cmc_mode_t;

  // Gray order along idle, prep, step, fetch
  typedef enum logic [1:0] {
    CMC_IDLE  = 2'h0,
    CMC_PREP  = 2'h1,
    CMC_STEP  = 2'h3,
    CMC_FETCH = 2'h2
  } cmc_state_t;

  typedef struct packed {
    logic      moduleOn;
    logic      intEnable;
    logic      xUnsigned;
    logic      keepZ;
    logic      keepY;
    logic      keepX;
    cmc_mode_t mode;
    logic      vectoring;
  } cmc_ctrl_t;

  localparam cmc_ctrl_t CMC_CTRL_RESET = 9'h100;

  typedef struct packed {
    cmc_state_t               fsm;
    logic [3:0]               iter;
    cmc_ctrl_t                ctrl;
    logic [15:0]              xOp;
    logic [15:0]              yOp;
    logic [15:0]              zOp;
    logic signed [25:0]       x;
    logic signed [25:0]       y;
    logic signed [20:0]       z;
    logic                     eoc;
    logic                     irq;
    logic                     ack;
    logic                     waitReq;
    logic [31:0]              rdata;
  } cmc_regs_t;

  localparam logic [19:0] CMC_ATAN_LUT [16] = '{
    20'h20000, 20'h12e40, 20'h09fb3, 20'h05111, 20'h028b1, 20'h0145d,
    20'h00a2f, 20'h00518, 20'h0028c, 20'h00146, 20'h000a3, 20'h00051,
    20'h00029, 20'h00014, 20'h0000a, 20'h00005};

  // Indexed by shift; slot zero is never used
  localparam logic [19:0] CMC_ATANH_LUT [16] = '{
    20'h00000, 20'h16618, 20'h0a681, 20'h051ea, 20'h028cc, 20'h01461,
    20'h00a30, 20'h00518, 20'h0028c, 20'h00146, 20'h000a3, 20'h00051,
    20'h00029, 20'h00014, 20'h0000a, 20'h00005};

  // Hyperbolic shifts repeat at 4 and 13 for convergence
  function automatic logic [3:0] cmc_hyp_shift(input logic [3:0] i);
    logic [3:0] s;
    s = i;
    if (i < CMC_HYP_REP_A) begin
      s = i + 4'h1;
    end else if (i >= CMC_HYP_REP_B) begin
      s = i - 4'h1;
    end
    return s;
  endfunction

endpackage

//--- design/cmc_top.sv
// CORDIC coprocessor kernel with Avalon-MM register slave
`timescale 1ns/10ps
module cmc_top
  import cmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             calcIrq
);

  ////////////////////////////////////////////////////////////////////////////

  cmc_regs_t          r;
  cmc_regs_t          next_r;
  logic [19:0]        lutEntry;
  logic               nextAck;
  logic               doWrite;
  logic               startReq;
  logic [15:0]        wMask;
  logic [15:0]        wData;
  logic [9:0]         ctrlMask;
  logic [9:0]         ctrlWord;
  logic [9:0]         ctrlNew;
  logic [15:0]        xRes;
  logic [15:0]        yRes;
  logic [15:0]        zRes;
  logic [31:0]        readMux;
  logic [3:0]         shift;
  logic               dirPos;
  logic signed [25:0] xShift;
  logic signed [25:0] yShift;
  logic signed [20:0] zEntry;
  logic               isCirc;
  logic               isHyp;

  ////////////////////////////////////////////////////////////////////////////

  cmc_lut_rom u_lut (
    .clock  (clock),
    .resetn (resetn),
    .mode   (r.ctrl.mode),
    .iter   (r.iter),
    .entry  (lutEntry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result views of the wide kernel

  always_comb begin
    // Low bits simply dropped
    yRes = r.y[23:8]; // RULE6 RULE17
    zRes = r.z[19:4]; // RULE14 RULE16
    if (!r.ctrl.xUnsigned) begin
      xRes = r.x[23:8]; // RULE11
    end else if (r.x[25]) begin
      xRes = 16'h0000; // RULE11
    end else if (r.x[24]) begin
      // Saturate rather than wrap past the view
      xRes = 16'hffff; // RULE11
    end else begin
      xRes = r.x[23:8]; // RULE11
    end
  end

  always_comb begin
    case (avs_address)
      CMC_REG_CTRL: begin
        readMux = {22'h000000, r.ctrl, 1'b0};
      end
      CMC_REG_STAT: begin
        readMux = {30'h00000000, r.eoc, (r.fsm != CMC_IDLE)}; // RULE20
      end
      CMC_REG_XDAT: begin
        readMux = {16'h0000, xRes};
      end
      CMC_REG_YDAT: begin
        readMux = {16'h0000, yRes};
      end
      CMC_REG_ZDAT: begin
        readMux = {16'h0000, zRes};
      end
      default: begin
        readMux = 32'h00000000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Kernel datapath for one iteration

  always_comb begin
    isCirc = (r.ctrl.mode == CMC_CIRCULAR);
    isHyp  = (r.ctrl.mode == CMC_HYPERBOLIC);
    shift  = isHyp ? cmc_hyp_shift(r.iter) : r.iter;
    xShift = r.x >>> shift; // RULE17
    yShift = r.y >>> shift;
    zEntry = {lutEntry[19], lutEntry};
    // Vectoring drives Y to zero, rotation drives Z to zero
    if (r.ctrl.vectoring) begin
      dirPos = r.y[25]; // RULE1
    end else begin
      dirPos = !r.z[20]; // RULE1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode, control and sequencing

  always_comb begin
    next_r   = r;
    wMask    = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wData    = avs_writedata[15:0];
    ctrlMask = {avs_byteenable[1], wMask[8:0]};
    ctrlWord = avs_writedata[9:0];
    ctrlNew  = ({r.ctrl, 1'b0} & ~ctrlMask) | (ctrlWord & ctrlMask);
    startReq = 1'b0;

    // One wait cycle, then a single acknowledge cycle
    nextAck        = (avs_read || avs_write) && !r.ack;
    doWrite        = avs_write && r.ack;
    next_r.ack     = nextAck;
    next_r.waitReq = !nextAck;
    if (nextAck && avs_read) begin
      next_r.rdata = readMux;
    end

    if (doWrite) begin
      case (avs_address)
        CMC_REG_CTRL: begin
          next_r.ctrl = ctrlNew[CMC_CTRL_MSB:CMC_CTRL_LSB];
          startReq    = avs_byteenable[0] && wData[CMC_START_BIT];
        end
        CMC_REG_STAT: begin
          if (avs_byteenable[0] && wData[CMC_EOC_BIT]) begin
            next_r.eoc = 1'b0; // RULE20
          end
        end
        CMC_REG_XDAT: begin
          next_r.xOp = (r.xOp & ~wMask) | (wData & wMask); // RULE6
        end
        CMC_REG_YDAT: begin
          next_r.yOp = (r.yOp & ~wMask) | (wData & wMask); // RULE6
        end
        CMC_REG_ZDAT: begin
          next_r.zOp = (r.zOp & ~wMask) | (wData & wMask); // RULE6
        end
        default: begin
          next_r.ctrl = r.ctrl;
        end
      endcase
    end

    // Module off stands for a stopped clock: kernel frozen
    if (r.ctrl.moduleOn) begin // RULE5
      case (r.fsm)
        CMC_IDLE: begin
          // Start while busy is ignored
          if (startReq) begin
            next_r.fsm  = CMC_PREP;
            next_r.iter = 4'h0;
            next_r.eoc  = 1'b0; // RULE20
            if (!next_r.ctrl.keepX) begin // RULE9
              next_r.x = {{2{r.xOp[15]}}, r.xOp, 8'h00}; // RULE7
            end
            if (!next_r.ctrl.keepY) begin // RULE9
              next_r.y = {{2{r.yOp[15]}}, r.yOp, 8'h00}; // RULE7
            end
            if (!next_r.ctrl.keepZ) begin // RULE9
              next_r.z = {r.zOp[15], r.zOp, 4'h0}; // RULE8
            end
          end
        end
        CMC_PREP: begin
          next_r.fsm = CMC_STEP;
          // Fold into the right half plane; Z overflow wraps
          if (isCirc && r.ctrl.vectoring && r.x[25]) begin
            next_r.x = -r.x; // RULE3
            next_r.y = -r.y; // RULE3
            next_r.z = r.z + CMC_Z_PI; // RULE3
          end
          if (isCirc && !r.ctrl.vectoring) begin
            if (r.z > CMC_Z_HALF_PI) begin
              next_r.x = -r.x; // RULE4
              next_r.y = -r.y; // RULE4
              next_r.z = r.z - CMC_Z_PI; // RULE4
            end else if (r.z < -CMC_Z_HALF_PI) begin
              next_r.x = -r.x; // RULE4
              next_r.y = -r.y; // RULE4
              next_r.z = r.z + CMC_Z_PI; // RULE4
            end
          end
        end
        CMC_STEP: begin
          if (dirPos) begin
            next_r.y = r.y + xShift; // RULE1
            next_r.z = r.z - zEntry; // RULE1
            if (isCirc) begin
              next_r.x = r.x - yShift;
            end else if (isHyp) begin
              next_r.x = r.x + yShift;
            end
          end else begin
            next_r.y = r.y - xShift; // RULE1
            next_r.z = r.z + zEntry; // RULE1
            if (isCirc) begin
              next_r.x = r.x + yShift;
            end else if (isHyp) begin
              next_r.x = r.x - yShift;
            end
          end
          if (r.iter == CMC_LAST_ITER) begin // RULE10
            next_r.fsm = CMC_IDLE;
            // Set after any clear in this cycle, so it wins
            next_r.eoc = 1'b1; // RULE18 RULE20
          end else begin
            next_r.iter = r.iter + 4'h1;
            // Table output is registered, so one fetch cycle
            next_r.fsm  = CMC_FETCH;
          end
        end
        CMC_FETCH: begin
          next_r.fsm = CMC_STEP;
        end
        default: begin
          next_r.fsm = CMC_IDLE;
        end
      endcase
    end

    // Level request towards the shared level 9 node
    next_r.irq = next_r.eoc && next_r.ctrl.intEnable; // RULE18 RULE19
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r.fsm     <= CMC_IDLE;
      r.iter    <= 4'h0;
      r.ctrl    <= CMC_CTRL_RESET;
      r.xOp     <= 16'h0000;
      r.yOp     <= 16'h0000;
      r.zOp     <= 16'h0000;
      r.x       <= 26'sh0000000;
      r.y       <= 26'sh0000000;
      r.z       <= 21'sh000000;
      r.eoc     <= 1'b0;
      r.irq     <= 1'b0;
      r.ack     <= 1'b0;
      r.waitReq <= 1'b1;
      r.rdata   <= 32'h00000000;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.waitReq;
  assign calcIrq         = r.irq;

endmodule

//--- testbench/cmc_cpu_model.sv
// Host processor model: register bus master
`timescale 1ns/10ps
module cmc_cpu_model (
  input  wire logic        clock,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [4:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable
);
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Held until answered; bounded so a dead slave cannot hang the run
  task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = 32'h0;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) begin
        ok = 1'b1;
        q = avs_readdata;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

//--- testbench/cmc_top_asserts.sv
// Port checker for the coprocessor bus and completion line
`timescale 1ns/10ps
module cmc_top_asserts
  import cmc_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        calcIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  logic anyReq;
  logic ackW;
  logic startGo;
  logic intOnW;
  logic unmapped;
  assign anyReq = avs_read || avs_write;
  assign ackW = !avs_waitrequest && avs_write;
  // Only starts that also enable the interrupt are timed here
  assign startGo = ackW && avs_address == CMC_REG_CTRL && avs_byteenable[1:0] == 2'h3
    && avs_writedata[9:8] == 2'h3 && avs_writedata[0];
  assign intOnW = ackW && avs_address == CMC_REG_CTRL && avs_writedata[8];
  assign unmapped = !(avs_address inside {CMC_REG_CTRL, CMC_REG_STAT, CMC_REG_XDAT,
    CMC_REG_YDAT, CMC_REG_ZDAT});
  sequence s_calc_done;
    ##32 !calcIrq ##1 calcIrq;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_done_timing: assert property (startGo |-> s_calc_done)
    else $error("completion not raised at the fixed calculation time");
  a_start_clears: assert property (startGo |=> !calcIrq [*8])
    else $error("completion line high during a calculation");
  a_irq_cause: assert property ($rose(calcIrq) |-> $past(startGo, 33) || $past(intOnW))
    else $error("completion line rose without cause");
  a_irq_sticky: assert property ($fell(calcIrq) |-> $past(ackW))
    else $error("completion line fell without a write");
  a_wait_answer: assert property (anyReq && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(anyReq))
    else $error("answer without a request");
  a_unmapped_zero: assert property (!avs_waitrequest && avs_read && unmapped |->
    avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_read_stands: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data changed outside an answer");
endmodule
bind cmc_top cmc_top_asserts chk_u (.clock, .resetn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .calcIrq);

//--- testbench/tb.sv
// Self-checking bench for the coprocessor
`timescale 1ns/10ps
module tb
  import cmc_pkg::*;
;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        calcIrq;
  int          errorCnt = 0;
  int          checksDone = 0;
  logic [31:0] q;
  // Ctrl, x, y, z in; x, y, z out; tolerance for truncation
  logic [15:0] vec [10][8] = '{
    '{16'h0300, 16'h0100, 16'h0010, 16'h0801, 16'h0100, 16'h0110, 16'h0000, 16'h0001},
    '{16'h0320, 16'h0100, 16'h7777, 16'h0801, 16'h0100, 16'h0210, 16'h0000, 16'h0001},
    '{16'h020a, 16'h0400, 16'h0200, 16'h0000, 16'h0400, 16'h0000, 16'h0400, 16'h0001},
    '{16'h0206, 16'h1000, 16'h1000, 16'h0000, 16'h2543, 16'h0000, 16'h2000, 16'h0008},
    '{16'h0286, 16'h8000, 16'h0000, 16'h0000, 16'hd2c9, 16'h0000, 16'h8000, 16'h0008},
    '{16'h0304, 16'h1000, 16'h0000, 16'h4000, 16'h0000, 16'h1a59, 16'h0000, 16'h0008},
    '{16'h0204, 16'h1000, 16'h0000, 16'h8000, 16'he5a7, 16'h0000, 16'h0000, 16'h0008},
    '{16'h020e, 16'h1000, 16'h0800, 16'h0000, 16'h0b7a, 16'h0000, 16'h1661, 16'h0008},
    '{16'h020c, 16'h1000, 16'h0000, 16'h1661, 16'h0f4d, 16'h07a6, 16'h0000, 16'h0008},
    // Kept X and Z: the 7777 operands must not reach the kernel
    '{16'h0250, 16'h7777, 16'h0123, 16'h7777, 16'h0f4d, 16'h0123, 16'h0000, 16'h0008}};
  always #2 clock = ~clock;
  cmc_top dut_u (.clock, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .calcIrq);
  cmc_cpu_model cpu_u (.clock, .avs_readdata, .avs_waitrequest, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict();
    $display("checks %0d, mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Modular difference, so a result near the wrap point still matches
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
    logic [15:0] d;
    d = got - exp;
    checksDone++;
    if ($isunknown(got) || $signed(d) > $signed(tol) || $signed(d) < -$signed(tol)) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    logic ok;
    cpu_u.access(w, a, {16'h0, d}, q, ok);
    if (!ok) begin
      errorCnt++;
      giveVerdict();
    end
  endtask
  task automatic waitDone();
    for (int n = 0; n < 60 && q[1] !== 1'b1; n++) begin
      acc(1'b0, CMC_REG_STAT, 16'h0);
    end
    if (q[1] !== 1'b1) begin
      errorCnt++;
      giveVerdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    acc(1'b0, CMC_REG_CTRL, 16'h0);
    cmp(q[15:0], 16'h0200, 16'h0);
    acc(1'b0, CMC_REG_STAT, 16'h0);
    cmp(q[15:0], 16'h0000, 16'h0);
    acc(1'b1, 5'h14, 16'hffff);
    acc(1'b0, 5'h14, 16'h0);
    cmp(q[15:0], 16'h0000, 16'h0);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      acc(1'b1, CMC_REG_XDAT, vec[i][1]);
      acc(1'b1, CMC_REG_YDAT, vec[i][2]);
      acc(1'b1, CMC_REG_ZDAT, vec[i][3]);
      acc(1'b1, CMC_REG_CTRL, vec[i][0] | 16'h1);
      acc(1'b0, CMC_REG_STAT, 16'h0);
      cmp(q[15:0], 16'h0001, 16'h0);
      waitDone();
      acc(1'b0, CMC_REG_STAT, 16'h0);
      cmp(q[15:0], 16'h0002, 16'h0);
      cmp({15'h0, calcIrq}, {15'h0, vec[i][0][8]}, 16'h0);
      acc(1'b0, CMC_REG_XDAT, 16'h0);
      cmp(q[15:0], vec[i][4], vec[i][7]);
      acc(1'b0, CMC_REG_YDAT, 16'h0);
      cmp(q[15:0], vec[i][5], vec[i][7]);
      acc(1'b0, CMC_REG_ZDAT, 16'h0);
      cmp(q[15:0], vec[i][6], vec[i][7]);
      acc(1'b1, CMC_REG_STAT, 16'h0002);
      acc(1'b0, CMC_REG_STAT, 16'h0);
      cmp(q[15:0], 16'h0000, 16'h0);
      $display("test %0d done", i);
    end
    // Switching the module off mid-run must freeze, not abort
    acc(1'b1, CMC_REG_XDAT, 16'h1000);
    acc(1'b1, CMC_REG_YDAT, 16'h0000);
    acc(1'b1, CMC_REG_ZDAT, 16'h4000);
    acc(1'b1, CMC_REG_CTRL, 16'h0205);
    acc(1'b1, CMC_REG_CTRL, 16'h0004);
    repeat (60) @(posedge clock);
    acc(1'b0, CMC_REG_STAT, 16'h0);
    cmp(q[15:0], 16'h0001, 16'h0);
    acc(1'b1, CMC_REG_CTRL, 16'h0204);
    waitDone();
    acc(1'b0, CMC_REG_YDAT, 16'h0);
    cmp(q[15:0], 16'h1a59, 16'h0008);
    $display("test freeze done");
    giveVerdict();
  end
endmodule
